// [sysopt_regs.vh]
`ifndef SOD_SYSOPT_REGS_VH
`define SOD_SYSOPT_REGS_VH

// ***************************************************************
// Register offsets within the high register page (chosen locally)
// ***************************************************************
`define SOD_ADDR_W            8
`define SOD_OFF_DEBUG_RESET   8'h01
`define SOD_OFF_OPTIONS_ONE   8'h02
`define SOD_OFF_OPTIONS_TWO   8'h03
`define SOD_OFF_IDENT_HIGH    8'h06
`define SOD_OFF_IDENT_LOW     8'h07

// ***************************************************************
// Field positions
// ***************************************************************
`define SOD_DBG_TRIGGER_BIT   0
`define SOD_O1_TIMEOUT_HI     7
`define SOD_O1_TIMEOUT_LO     6
`define SOD_O1_STOP_BIT       5
`define SOD_O1_I2C_BIT        2
`define SOD_O2_WDCLK_BIT      7
`define SOD_O2_WINDOW_BIT     6
`define SOD_O2_CMP_BIT        4
`define SOD_O2_T2C1_BIT       3
`define SOD_O2_T2C0_BIT       2
`define SOD_O2_T1C1_BIT       1
`define SOD_O2_T1C0_BIT       0

// ***************************************************************
// Reset values and implemented-bit masks
// ***************************************************************
`define SOD_O1_RESET          8'h00
`define SOD_O1_MASK           8'hE4
`define SOD_O2_RESET          8'h00
`define SOD_O2_MASK           8'hDF
`define SOD_O2_ONCE_MASK      8'hC0
`define SOD_READ_ZERO         8'h00

// ***************************************************************
// Identification (part number value is arbitrary)
// ***************************************************************
`define SOD_SERIES_BIT        1'b1
`define SOD_PART_NUMBER       12'h0_5C3
`define SOD_ID_RESERVED       3'h0

// ***************************************************************
// Timing counts
// ***************************************************************
`define SOD_RESET_PULSE_CYC   4'h4

`endif

// [sod_system_options.v]
`timescale 1ns/1ps

// What this block does
// - Debug reset register ignores writes from the user program; only debug link writes.
// - Reading the debug reset register always returns zero.
// - Debug link writing one to bit 0 forces a full MCU reset.
// - Options one accepts only the first write after reset; always readable.
// - Bits 7:6 of options one are write-once watchdog timeout select.
// - Stop allow bit 5 write-once; stop while clear gives illegal-opcode reset.
// - I2C pins on port A bits 2,3 when clear, port B bits 6,7 when set.
// - Write-once bit 7 of options two selects 1 kHz or bus watchdog clock.
// - Window bit 6 write-once; early reset-status writes reset the MCU.
// - Window mode takes effect only when watchdog runs from bus clock.
// - Bit 4 of options two connects comparator output to timer one channel 0.
// - Write-once bits of options two take one write until next reset.
// - Read-only identification holds 12-bit part number, upper four in high bits 3:0.
// - High identification bits 6:4 reserved; read as zero, writes ignored.
// - High identification bit 7 is a fixed series tie-off; writes ignored.
// - Debug-forced reset leaves all reset status flags cleared.
module sod_system_options
(
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire [7:0]  bus_addr,
  input  wire [7:0]  bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  input  wire        bus_from_debug,
  input  wire        stop_attempt,
  input  wire        status_write,
  input  wire        watchdog_late_window,
  output reg  [7:0]  bus_rdata,
  output reg         debug_reset_req,
  output reg         reset_flags_clear,
  output reg         illegal_stop_reset,
  output reg         stop_enter,
  output reg         window_violation_reset,
  output reg  [1:0]  watchdog_timeout_sel,
  output reg         watchdog_clock_sel,
  output reg         watchdog_window_en,
  output reg         stop_allow,
  output reg         i2c_pin_sel,
  output reg         comparator_to_capture_en,
  output reg         timer2_ch1_pin_sel,
  output reg         timer2_ch0_pin_sel,
  output reg         timer1_ch1_pin_sel,
  output reg         timer1_ch0_pin_sel
);

`include "sysopt_regs.vh"

  // ***************************************************************
  // Address decode
  // ***************************************************************
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // ***************************************************************
  // Register state
  // ***************************************************************
  reg  [7:0] system_options_one;
  reg  [7:0] system_options_two;
  reg        options_one_written;
  reg        options_two_written;
  reg  [3:0] reset_pulse_cnt;
  reg  [7:0] next_rdata;

  // ***************************************************************
  // Write strobes
  // ***************************************************************
  wire       wr_debug = bus_wr && hit(bus_addr, `SOD_OFF_DEBUG_RESET);
  wire       wr_opt1  = bus_wr && hit(bus_addr, `SOD_OFF_OPTIONS_ONE);
  wire       wr_opt2  = bus_wr && hit(bus_addr, `SOD_OFF_OPTIONS_TWO);
  // Only the background debug link may fire the forced reset
  wire       debug_fire = wr_debug && bus_from_debug
                          && bus_wdata[`SOD_DBG_TRIGGER_BIT];
  // Window checks apply only with the bus clock selected
  wire       window_live = system_options_two[`SOD_O2_WINDOW_BIT]
                           && system_options_two[`SOD_O2_WDCLK_BIT];

  // ***************************************************************
  // Identification values
  // ***************************************************************
  // Reserved bits are tied low so repeated reads always agree
  localparam [11:0] part_number      = `SOD_PART_NUMBER;
  localparam [7:0]  ident_high_value = {`SOD_SERIES_BIT, `SOD_ID_RESERVED, part_number[11:8]};
  localparam [7:0]  ident_low_value  = part_number[7:0];

  // ***************************************************************
  // Field views
  // ***************************************************************
  // Named views keep the field positions in one place
  wire [1:0] timeout_field = system_options_one[`SOD_O1_TIMEOUT_HI:`SOD_O1_TIMEOUT_LO];
  wire       stop_field    = system_options_one[`SOD_O1_STOP_BIT];
  wire       i2c_field     = system_options_one[`SOD_O1_I2C_BIT];
  wire       wdclk_field   = system_options_two[`SOD_O2_WDCLK_BIT];
  wire       cmp_field     = system_options_two[`SOD_O2_CMP_BIT];
  wire       t2c1_field    = system_options_two[`SOD_O2_T2C1_BIT];
  wire       t2c0_field    = system_options_two[`SOD_O2_T2C0_BIT];
  wire       t1c1_field    = system_options_two[`SOD_O2_T1C1_BIT];
  wire       t1c0_field    = system_options_two[`SOD_O2_T1C0_BIT];

  // ***************************************************************
  // Options register one
  // ***************************************************************
  // A write with the clock enable low never reaches the lock
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      system_options_one  <= `SOD_O1_RESET;
      options_one_written <= 1'b0;
    end
    else if (clk_en && wr_opt1 && !options_one_written)
    begin
      // First write wins; later writes are dropped silently
      system_options_one  <= bus_wdata & `SOD_O1_MASK;
      options_one_written <= 1'b1;
    end
  end

  // ***************************************************************
  // Options register two
  // ***************************************************************
  // Only the watchdog bits lock; pin and comparator bits stay writable
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      system_options_two  <= `SOD_O2_RESET;
      options_two_written <= 1'b0;
    end
    else if (clk_en && wr_opt2)
    begin
      options_two_written <= 1'b1;
      if (!options_two_written)
        system_options_two <= bus_wdata & `SOD_O2_MASK;
      else
        system_options_two <= (system_options_two & `SOD_O2_ONCE_MASK)
                              | (bus_wdata & `SOD_O2_MASK & ~`SOD_O2_ONCE_MASK);
    end
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  always @*
  begin
    next_rdata = `SOD_READ_ZERO;
    if (hit(bus_addr, `SOD_OFF_DEBUG_RESET))
      next_rdata = `SOD_READ_ZERO;
    else if (hit(bus_addr, `SOD_OFF_OPTIONS_ONE))
      next_rdata = system_options_one;
    else if (hit(bus_addr, `SOD_OFF_OPTIONS_TWO))
      next_rdata = system_options_two;
    else if (hit(bus_addr, `SOD_OFF_IDENT_HIGH))
      // Reserved bits read as zero; writes to identity have no target
      next_rdata = ident_high_value;
    else if (hit(bus_addr, `SOD_OFF_IDENT_LOW))
      next_rdata = ident_low_value;
  end

  // ***************************************************************
  // Read data register
  // ***************************************************************
  // Read data holds between reads so the master may take it late
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      bus_rdata <= `SOD_READ_ZERO;
    else if (clk_en && bus_rd)
      bus_rdata <= next_rdata;
  end

  // ***************************************************************
  // Debug forced reset
  // ***************************************************************
  // The request is stretched so it survives the reset it causes;
  // a further debug write inside the stretch restarts the count
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      debug_reset_req   <= 1'b0;
      reset_flags_clear <= 1'b0;
      reset_pulse_cnt   <= 4'h0;
    end
    else if (clk_en)
    begin
      if (debug_fire)
      begin
        reset_pulse_cnt   <= `SOD_RESET_PULSE_CYC;
        debug_reset_req   <= 1'b1;
        reset_flags_clear <= 1'b1;
      end
      else if (reset_pulse_cnt != 4'h0)
      begin
        reset_pulse_cnt   <= reset_pulse_cnt - 4'h1;
        debug_reset_req   <= (reset_pulse_cnt != 4'h1);
        reset_flags_clear <= (reset_pulse_cnt != 4'h1);
      end
    end
  end

  // ***************************************************************
  // Stop handling
  // ***************************************************************
  // A refused stop resets the part, so a stray stop cannot hang it
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      illegal_stop_reset <= 1'b0;
      stop_enter         <= 1'b0;
    end
    else if (clk_en)
    begin
      illegal_stop_reset <= stop_attempt
                            && !stop_field;
      stop_enter         <= stop_attempt
                            && stop_field;
    end
  end

  // ***************************************************************
  // Window watchdog check
  // ***************************************************************
  // Only writes in the early part of a live window cause a reset
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      window_violation_reset <= 1'b0;
    else if (clk_en)
      window_violation_reset <= status_write && window_live
                                && !watchdog_late_window;
  end

  // ***************************************************************
  // Options one field outputs
  // ***************************************************************
  // Registered copies keep every output straight from a flip-flop
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      watchdog_timeout_sel <= 2'b00;
    else if (clk_en)
      watchdog_timeout_sel <= timeout_field;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      stop_allow <= 1'b0;
    else if (clk_en)
      stop_allow <= stop_field;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      i2c_pin_sel <= 1'b0;
    else if (clk_en)
      i2c_pin_sel <= i2c_field;
  end

  // ***************************************************************
  // Options two field outputs
  // ***************************************************************
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      watchdog_clock_sel <= 1'b0;
    else if (clk_en)
      watchdog_clock_sel <= wdclk_field;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      watchdog_window_en <= 1'b0;
    else if (clk_en)
      watchdog_window_en <= window_live;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      comparator_to_capture_en <= 1'b0;
    else if (clk_en)
      comparator_to_capture_en <= cmp_field;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      timer2_ch1_pin_sel <= 1'b0;
    else if (clk_en)
      timer2_ch1_pin_sel <= t2c1_field;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      timer2_ch0_pin_sel <= 1'b0;
    else if (clk_en)
      timer2_ch0_pin_sel <= t2c0_field;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      timer1_ch1_pin_sel <= 1'b0;
    else if (clk_en)
      timer1_ch1_pin_sel <= t1c1_field;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      timer1_ch0_pin_sel <= 1'b0;
    else if (clk_en)
      timer1_ch0_pin_sel <= t1c0_field;
  end

endmodule // sod_system_options

// [sod_sysopt_monitor.sv]
`timescale 1ns/1ps
`include "sysopt_regs.vh"
module sod_sysopt_monitor
(
  input wire       ref_clk, sys_rst, clk_en, bus_wr, bus_rd, bus_from_debug,
  input wire       stop_attempt, status_write, watchdog_late_window, stop_allow,
  input wire [7:0] bus_addr, bus_wdata, bus_rdata,
  input wire       debug_reset_req, reset_flags_clear, illegal_stop_reset, stop_enter,
  input wire       window_violation_reset, watchdog_clock_sel, watchdog_window_en,
  input wire [1:0] watchdog_timeout_sel
);
  // ********************
  // Protocol watch
  // ********************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire wr_en = clk_en && bus_wr;
  reg  opt1_done;
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      opt1_done <= 1'b0;
    else if (wr_en && bus_addr == `SOD_OFF_OPTIONS_ONE)
      opt1_done <= 1'b1;
  end
  a_dbg_read_zero: assert property (clk_en && bus_rd && bus_addr == `SOD_OFF_DEBUG_RESET
    |=> bus_rdata == 8'h00) else $error("debug reset register read not zero");
  a_user_no_reset: assert property (wr_en && !bus_from_debug && !debug_reset_req
    && bus_addr == `SOD_OFF_DEBUG_RESET |=> !debug_reset_req) else $error("user write reset");
  a_dbg_pulse_len: assert property (wr_en && bus_from_debug && bus_wdata[0]
    && bus_addr == `SOD_OFF_DEBUG_RESET |=> debug_reset_req[*4] ##1 !debug_reset_req)
    else $error("debug reset pulse length wrong");
  a_flags_stay_clear: assert property (reset_flags_clear == debug_reset_req)
    else $error("reset status clear not tied to debug reset");
  a_stop_illegal: assert property (clk_en && stop_attempt && !stop_allow
    |=> illegal_stop_reset && !stop_enter) else $error("stop while disallowed not refused");
  a_stop_enters: assert property (clk_en && stop_attempt && stop_allow
    |=> stop_enter && !illegal_stop_reset) else $error("allowed stop not entered");
  a_window_early: assert property (clk_en && status_write && watchdog_window_en
    && !watchdog_late_window |=> window_violation_reset) else $error("early write not reset");
  a_window_bus_clk: assert property (watchdog_window_en |-> watchdog_clock_sel)
    else $error("window mode without bus clock");
  a_opt1_frozen: assert property (opt1_done && wr_en && bus_addr == `SOD_OFF_OPTIONS_ONE
    |=> ##1 $stable({watchdog_timeout_sel, stop_allow})[*2]) else $error("second write taken");
  c_dbg_reset: cover property (debug_reset_req && reset_flags_clear);
  c_illegal: cover property (illegal_stop_reset);
  c_window: cover property (window_violation_reset);
endmodule // sod_sysopt_monitor
bind sod_system_options sod_sysopt_monitor u_mon (.*);

// [sod_bus_host.sv]
`timescale 1ns/1ps
module sod_bus_host
(
  input  wire       ref_clk,
  input  wire [7:0] bus_rdata,
  output reg  [7:0] bus_addr,
  output reg  [7:0] bus_wdata,
  output reg        bus_wr,
  output reg        bus_rd,
  output reg        bus_from_debug
);
  // ********************
  // Program and debug link cycles
  // ********************
  initial
  begin
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_from_debug = 1'b0;
  end
  task xfer(input rd, input dbg, input [7:0] addr, input [7:0] data, output [7:0] q);
  begin
    @(negedge ref_clk);
    bus_addr = addr;
    bus_wdata = data;
    bus_rd = rd;
    bus_wr = !rd;
    bus_from_debug = dbg;
    @(negedge ref_clk);
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_from_debug = 1'b0;
    // Released lines show inverted data so stale values never look valid
    bus_wdata = ~data;
    bus_addr = ~addr;
    @(negedge ref_clk);
    q = bus_rdata;
  end
  endtask
endmodule // sod_bus_host

// [tb.sv]
`timescale 1ns/1ps
`include "sysopt_regs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb;
  // ********************
  // Bench
  // ********************
  localparam [11:0] PN = `SOD_PART_NUMBER;
  reg ref_clk = 0, sys_rst = 1, clk_en = 1, stop_attempt = 0, status_write = 0;
  reg watchdog_late_window = 0;
  wire [7:0] bus_addr, bus_wdata, bus_rdata;
  wire bus_wr, bus_rd, bus_from_debug, debug_reset_req, reset_flags_clear, illegal_stop_reset;
  wire stop_enter, window_violation_reset, watchdog_clock_sel, watchdog_window_en, stop_allow;
  wire i2c_pin_sel, comparator_to_capture_en, timer2_ch1_pin_sel, timer2_ch0_pin_sel;
  wire timer1_ch1_pin_sel, timer1_ch0_pin_sel;
  wire [1:0] watchdog_timeout_sel;
  integer mismatches = 0, check_count = 0, cycles = 0, pulses = 0;
  reg [7:0] q;
  always #2.5 ref_clk = ~ref_clk;
  sod_system_options u_dut (.*);
  sod_bus_host u_host (.*);
  always @(negedge ref_clk) if (debug_reset_req === 1'b1 && reset_flags_clear === 1'b1) pulses++;
  always @(posedge ref_clk) begin cycles++; if (cycles == 2000) begin mismatches++; summarize; end end
  task wr(input dbg, input [7:0] a, input [7:0] d); u_host.xfer(1'b0, dbg, a, d, q); endtask
  task rd(input [7:0] a, input [7:0] e); begin u_host.xfer(1'b1, 1'b0, a, 8'h00, q); `CHK("rdata", e, q) end endtask
  task pulse(input stop, input [1:0] e);
  begin
    stop_attempt = stop;
    status_write = !stop;
    @(negedge ref_clk);
    stop_attempt = 0;
    status_write = 0;
    `CHK("pulse", e, stop ? {illegal_stop_reset, stop_enter} : {window_violation_reset, 1'b0})
  end
  endtask
  task do_reset; begin sys_rst = 1; repeat (5) @(negedge ref_clk); sys_rst = 0; end endtask
  task t_ident;
  begin
    wr(0, `SOD_OFF_IDENT_HIGH, 8'h70);
    wr(0, `SOD_OFF_IDENT_LOW, ~PN[7:0]);
    rd(`SOD_OFF_IDENT_HIGH, {1'b1, 3'h0, PN[11:8]});
    rd(`SOD_OFF_IDENT_LOW, PN[7:0]);
    rd(8'h00, 8'h00);
  end
  endtask
  task t_debug;
  begin
    pulses = 0;
    wr(0, `SOD_OFF_DEBUG_RESET, 8'hFF);
    repeat (6) @(negedge ref_clk);
    `CHK("user reset", 0, pulses)
    wr(1, `SOD_OFF_DEBUG_RESET, 8'h01);
    repeat (6) @(negedge ref_clk);
    `CHK("debug reset", 4, pulses)
    rd(`SOD_OFF_DEBUG_RESET, 8'h00);
  end
  endtask
  task t_opt1;
  begin
    clk_en = 0;
    wr(0, `SOD_OFF_OPTIONS_ONE, 8'hFF);
    clk_en = 1;
    rd(`SOD_OFF_OPTIONS_ONE, 8'h00);
    pulse(1, 2'b10);
    wr(0, `SOD_OFF_OPTIONS_ONE, 8'hFF);
    wr(0, `SOD_OFF_OPTIONS_ONE, 8'h00);
    rd(`SOD_OFF_OPTIONS_ONE, 8'hE4);
    `CHK("opt1", 4'hF, {watchdog_timeout_sel, stop_allow, i2c_pin_sel})
    pulse(1, 2'b01);
  end
  endtask
  task t_opt2;
  begin
    wr(0, `SOD_OFF_OPTIONS_TWO, 8'hFF);
    rd(`SOD_OFF_OPTIONS_TWO, 8'hDF);
    `CHK("opt2", 7'h7F, {watchdog_clock_sel, watchdog_window_en, comparator_to_capture_en, timer2_ch1_pin_sel, timer2_ch0_pin_sel, timer1_ch1_pin_sel, timer1_ch0_pin_sel})
    wr(0, `SOD_OFF_OPTIONS_TWO, 8'h00);
    rd(`SOD_OFF_OPTIONS_TWO, 8'hC0);
    `CHK("pins", 5'h18, {watchdog_clock_sel, watchdog_window_en, comparator_to_capture_en, timer2_ch1_pin_sel, timer1_ch0_pin_sel})
    pulse(0, 2'b10);
    watchdog_late_window = 1;
    pulse(0, 2'b00);
    watchdog_late_window = 0;
    do_reset;
    wr(0, `SOD_OFF_OPTIONS_ONE, 8'h00);
    wr(0, `SOD_OFF_OPTIONS_ONE, 8'hFF);
    rd(`SOD_OFF_OPTIONS_ONE, 8'h00);
    wr(0, `SOD_OFF_OPTIONS_TWO, 8'h40);
    `CHK("window", 1'b0, watchdog_window_en)
    pulse(0, 2'b00);
  end
  endtask
  task summarize;
  begin
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    do_reset;
    t_ident;
    t_debug;
    t_opt1;
    t_opt2;
    summarize;
  end
endmodule // tb
